/* File: ubc_pkg.sv */
// package: register map, field positions and constants for the break control block
package ubc_pkg;
    localparam logic [3:0] UBC_OFS_CTRL = 4'h0;
    localparam logic [3:0] UBC_OFS_CNT_C = 4'h4;
    localparam logic [3:0] UBC_OFS_CNT_D = 4'h8;
    localparam logic [3:0] UBC_OFS_IRQ_STAT = 4'hC;
    localparam logic [3:0] UBC_OFS_IRQ_MASK = 4'hC;
    localparam logic [31:0] UBC_CTRL_RESET = 32'h00000000;
    localparam logic [31:0] UBC_CTRL_WMASK = 32'h0C1C2C2C;
    localparam logic [31:0] UBC_CTRL_FLAGS = 32'hC0C0C0C0;
    localparam int UBC_BIT_CPU_A = 31;
    localparam int UBC_BIT_DMA_A = 30;
    localparam int UBC_BIT_AFTER_A = 26;
    localparam int UBC_BIT_CPU_B = 23;
    localparam int UBC_BIT_DMA_B = 22;
    localparam int UBC_BIT_CHAIN_HI = 20;
    localparam int UBC_BIT_CHAIN_LO = 19;
    localparam int UBC_BIT_AFTER_B = 18;
    localparam int UBC_BIT_CPU_C = 15;
    localparam int UBC_BIT_DMA_C = 14;
    localparam int UBC_BIT_CNT_EN_C = 13;
    localparam int UBC_BIT_DATA_EN_C = 11;
    localparam int UBC_BIT_AFTER_C = 10;
    localparam int UBC_BIT_CPU_D = 7;
    localparam int UBC_BIT_DMA_D = 6;
    localparam int UBC_BIT_CNT_EN_D = 5;
    localparam int UBC_BIT_DATA_EN_D = 3;
    localparam int UBC_BIT_AFTER_D = 2;
    localparam int UBC_CNT_W = 12;
    localparam logic [11:0] UBC_CNT_RESET = 12'h000;
    localparam logic [11:0] UBC_CNT_ONE = 12'h001;
    typedef enum logic [1:0] {
        UBC_CHAIN_NONE,
        UBC_CHAIN_CD,
        UBC_CHAIN_BCD,
        UBC_CHAIN_ABCD
    } ubc_chain_t;
endpackage : ubc_pkg

/* File: ubc_exec_counter.sv */
// execution-count down counter for one channel
`timescale 1ns/1ps
module ubc_exec_counter
    import ubc_pkg::*;
#(
    parameter int W = UBC_CNT_W
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_load,
    input wire logic [W-1:0] i_load_value,
    input wire logic i_enable,
    input wire logic i_hit,
    output logic [W-1:0] o_count,
    output logic o_fire
);
    // count of one means the next hit fires
    always_comb begin
        o_fire = i_hit && (!i_enable || (o_count <= W'(UBC_CNT_ONE)));
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_count <= W'(UBC_CNT_RESET);
        end else if (i_load) begin
            o_count <= i_load_value;
        end else if (i_enable && i_hit && o_count > W'(UBC_CNT_ONE)) begin
            o_count <= o_count - W'(UBC_CNT_ONE);
        end
    end
endmodule // ubc_exec_counter

/* File: ubc_break_ctrl.sv */
// break channel control register, chaining, counters and interrupt
`timescale 1ns/1ps
// What this block does
// [RULE1] cpu-cycle match sets channel cpu flag
// [RULE2] dma-cycle match sets channel dma flag
// [RULE3] flags clear only by software write 0
// [RULE4] bits 20:19 select channel chaining mode
// [RULE5] bit 18 picks channel b fetch timing
// [RULE6] bit 10 picks channel c fetch timing
// [RULE7] bit 13 enables channel c count break
// [RULE8] bit 5 enables channel d count break
// [RULE9] bit 11 adds data compare to c
// [RULE10] reserved bits read zero, writes ignored
// [RULE11] chained break needs earlier channels first
// [RULE12] count decrements, fires after reaching one
// [RULE13] power-on reset clears whole control register
module ubc_break_ctrl
    import ubc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    input wire logic [3:0] i_cpu_hit,
    input wire logic [3:0] i_dma_hit,
    input wire logic [3:0] i_fetch,
    input wire logic i_data_hit_c,
    input wire logic i_data_hit_d,
    input wire logic i_exec_done,
    output logic [31:0] o_rdata,
    output logic o_break,
    output logic o_irq,
    output logic o_after_b,
    output logic o_after_c,
    output logic o_data_en_c
);
    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_reg;
    logic [3:0] stat_reg;
    logic [3:0] mask_reg;
    logic [2:0] seq_reg;
    logic [3:0] pend_reg;
    logic [3:0] raw_hit;
    logic [3:0] qual_hit;
    logic [3:0] chan_fire;
    logic [3:0] brk_now;
    logic [3:0] brk_late;
    logic [3:0] after_bits;
    logic [11:0] cnt_c;
    logic [11:0] cnt_d;
    logic fire_c;
    logic fire_d;
    logic brk_any;
    ubc_chain_t chain;

    // mask is written at the status offset; a read there clears status
    logic wr_ctrl;
    logic wr_cnt_c;
    logic wr_cnt_d;
    logic wr_mask;
    logic rd_stat;
    assign wr_ctrl = i_write && i_addr == UBC_OFS_CTRL;
    assign wr_cnt_c = i_write && i_addr == UBC_OFS_CNT_C;
    assign wr_cnt_d = i_write && i_addr == UBC_OFS_CNT_D;
    assign wr_mask = i_write && i_addr == UBC_OFS_IRQ_MASK;
    assign rd_stat = i_read && i_addr == UBC_OFS_IRQ_STAT;

    ////////////////////////////////////////////////////////////////////////////
    // [RULE4] chain mode decode
    assign chain = ubc_chain_t'({ctrl_reg[UBC_BIT_CHAIN_HI], ctrl_reg[UBC_BIT_CHAIN_LO]});
    assign after_bits = {ctrl_reg[UBC_BIT_AFTER_A], ctrl_reg[UBC_BIT_AFTER_B],
                         ctrl_reg[UBC_BIT_AFTER_C], ctrl_reg[UBC_BIT_AFTER_D]};

    always_comb begin
        raw_hit = i_cpu_hit | i_dma_hit;
        // [RULE9] data compare qualifier
        if (ctrl_reg[UBC_BIT_DATA_EN_C]) begin
            raw_hit[1] = raw_hit[1] && i_data_hit_c;
        end
        if (ctrl_reg[UBC_BIT_DATA_EN_D]) begin
            raw_hit[0] = raw_hit[0] && i_data_hit_d;
        end
    end

    // bit 3 is channel a, bit 0 is channel d
    ////////////////////////////////////////////////////////////////////////////
    // [RULE11] chained channels need predecessors
    always_comb begin
        qual_hit = raw_hit;
        unique case (chain)
            UBC_CHAIN_NONE: begin
                qual_hit = raw_hit;
            end
            UBC_CHAIN_CD: begin
                qual_hit[0] = raw_hit[0] && seq_reg[0];
                qual_hit[1] = 1'b0;
            end
            UBC_CHAIN_BCD: begin
                qual_hit[0] = raw_hit[0] && seq_reg[0];
                qual_hit[1] = 1'b0;
                qual_hit[2] = 1'b0;
            end
            UBC_CHAIN_ABCD: begin
                qual_hit[0] = raw_hit[0] && seq_reg[0];
                qual_hit[1] = 1'b0;
                qual_hit[2] = 1'b0;
                qual_hit[3] = 1'b0;
            end
        endcase
    end

    // seq_reg[2]=a seen, [1]=b seen, [0]=c seen in chain order
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            seq_reg <= 3'h0;
        end else if (wr_ctrl || chain == UBC_CHAIN_NONE) begin
            seq_reg <= 3'h0;
        end else begin
            if (chain == UBC_CHAIN_ABCD && raw_hit[3]) begin
                seq_reg[2] <= 1'b1;
            end
            if (raw_hit[2] && (chain == UBC_CHAIN_BCD || seq_reg[2])) begin
                seq_reg[1] <= 1'b1;
            end
            if (raw_hit[1] && (chain == UBC_CHAIN_CD || seq_reg[1])) begin
                seq_reg[0] <= 1'b1;
            end
            // chain restarts once the final channel breaks
            if (chan_fire[0]) begin
                seq_reg <= 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // [RULE7] channel c count qualifier
    ubc_exec_counter #(.W(UBC_CNT_W)) u_cnt_c (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_load(wr_cnt_c),
        .i_load_value(i_wdata[11:0]),
        .i_enable(ctrl_reg[UBC_BIT_CNT_EN_C]),
        .i_hit(qual_hit[1]),
        .o_count(cnt_c),
        .o_fire(fire_c)
    );

    // [RULE8] channel d count qualifier
    ubc_exec_counter #(.W(UBC_CNT_W)) u_cnt_d (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_load(wr_cnt_d),
        .i_load_value(i_wdata[11:0]),
        .i_enable(ctrl_reg[UBC_BIT_CNT_EN_D]),
        .i_hit(qual_hit[0]),
        .o_count(cnt_d),
        .o_fire(fire_d)
    );

    assign chan_fire = {qual_hit[3], qual_hit[2], fire_c, fire_d};

    ////////////////////////////////////////////////////////////////////////////
    // [RULE5] [RULE6] fetch break before or after execution
    assign brk_now = chan_fire & ~(i_fetch & after_bits);
    assign brk_late = chan_fire & i_fetch & after_bits;
    assign brk_any = (|brk_now) || (|pend_reg && i_exec_done);

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_reg <= 4'h0;
        end else if (i_exec_done) begin
            pend_reg <= brk_late;
        end else begin
            pend_reg <= pend_reg | brk_late;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_break <= 1'b0;
        end else begin
            o_break <= brk_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // [RULE13] power-on clear, [RULE10] reserved bits masked
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_reg <= UBC_CTRL_RESET;
        end else begin
            // [RULE3] written zero clears flag, one keeps it
            if (wr_ctrl) begin
                ctrl_reg <= (i_wdata & UBC_CTRL_WMASK)
                    | (ctrl_reg & i_wdata & UBC_CTRL_FLAGS);
            end
            for (int ch = 0; ch < 4; ch++) begin
                // [RULE1] cpu flag set wins over clear
                if (chan_fire[3 - ch] && i_cpu_hit[3 - ch]) begin
                    ctrl_reg[31 - 8 * ch] <= 1'b1;
                end
                // [RULE2] dma flag set wins over clear
                if (chan_fire[3 - ch] && i_dma_hit[3 - ch]) begin
                    ctrl_reg[30 - 8 * ch] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status: set wins over read clear
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            stat_reg <= 4'h0;
        end else if (rd_stat) begin
            stat_reg <= chan_fire;
        end else begin
            stat_reg <= stat_reg | chan_fire;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            mask_reg <= 4'h0;
        end else if (wr_mask) begin
            mask_reg <= i_wdata[7:4];
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |((stat_reg | chan_fire) & mask_reg & ~({4{rd_stat}} & ~chan_fire));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 32'h00000000;
        end else if (i_read) begin
            unique case (i_addr)
                UBC_OFS_CTRL: o_rdata <= ctrl_reg;
                UBC_OFS_CNT_C: o_rdata <= {20'h00000, cnt_c};
                UBC_OFS_CNT_D: o_rdata <= {20'h00000, cnt_d};
                UBC_OFS_IRQ_STAT: o_rdata <= {24'h000000, mask_reg, stat_reg};
                default: o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_after_b <= 1'b0;
            o_after_c <= 1'b0;
            o_data_en_c <= 1'b0;
        end else begin
            o_after_b <= ctrl_reg[UBC_BIT_AFTER_B];
            o_after_c <= ctrl_reg[UBC_BIT_AFTER_C];
            o_data_en_c <= ctrl_reg[UBC_BIT_DATA_EN_C];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // [RULE3] cpu flag c holds without a write
    flag_hold_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE3]
        (!wr_ctrl && ctrl_reg[UBC_BIT_CPU_C]) |=> ctrl_reg[UBC_BIT_CPU_C])
        else $error("cpu flag c dropped without a write");
    // [RULE10] reserved bits stay zero
    reserved_zero_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE10]
        (ctrl_reg & 32'h33231313) == 32'h00000000)
        else $error("reserved control bit set");
    // [RULE1] cpu hit on d sets flag
    cpu_flag_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE1]
        (chan_fire[0] && i_cpu_hit[0]) |=> ctrl_reg[UBC_BIT_CPU_D])
        else $error("cpu flag d not set");
    // [RULE2] dma hit on b sets flag
    dma_flag_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE2]
        (chan_fire[2] && i_dma_hit[2]) |=> ctrl_reg[UBC_BIT_DMA_B])
        else $error("dma flag b not set");
    // [RULE2] dma hit on c sets flag
    dma_flag_c_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE2]
        (chan_fire[1] && i_dma_hit[1]) |=> ctrl_reg[UBC_BIT_DMA_C])
        else $error("dma flag c not set");
    // [RULE11] c never fires in any chaining mode
    chain_c_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE11]
        (chain != UBC_CHAIN_NONE) |-> !chan_fire[1])
        else $error("chained channel c fired");
    // [RULE11] d waits for chain progress
    chain_d_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE11]
        (chain != UBC_CHAIN_NONE && !seq_reg[0]) |-> !chan_fire[0])
        else $error("chained channel d fired early");
    // [RULE4] independent mode passes hits
    chain_free_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE4]
        (chain == UBC_CHAIN_NONE) |-> (qual_hit == raw_hit))
        else $error("independent channel hit blocked");
    // [RULE4] a and b free in cd
    chain_cd_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE4]
        (chain == UBC_CHAIN_CD) |-> (chan_fire[3:2] == raw_hit[3:2]))
        else $error("channel a or b blocked in cd chain");
    // [RULE12] count above one blocks fire
    count_hold_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE12]
        (ctrl_reg[UBC_BIT_CNT_EN_D] && cnt_d > 12'h001) |-> !fire_d)
        else $error("channel d fired early");
    // [RULE12] count of one fires
    count_fire_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE12]
        (ctrl_reg[UBC_BIT_CNT_EN_D] && qual_hit[0] && cnt_d == 12'h001) |-> fire_d)
        else $error("channel d did not fire at count one");
    // [RULE8] count off fires directly
    count_off_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE8]
        (!ctrl_reg[UBC_BIT_CNT_EN_D] && qual_hit[0]) |-> fire_d)
        else $error("channel d held without count enable");
    // [RULE7] count decrements on hit
    count_dec_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE7]
        (ctrl_reg[UBC_BIT_CNT_EN_C] && qual_hit[1] && cnt_c > 12'h001 && !wr_cnt_c)
        |=> cnt_c == $past(cnt_c) - 12'h001)
        else $error("channel c count not decremented");
    // [RULE9] data miss blocks c
    data_gate_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE9]
        (ctrl_reg[UBC_BIT_DATA_EN_C] && !i_data_hit_c) |-> !chan_fire[1])
        else $error("channel c fired without data match");
    // [RULE9] data ignored when off
    data_free_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE9]
        (!ctrl_reg[UBC_BIT_DATA_EN_C] && chain == UBC_CHAIN_NONE
        && (i_cpu_hit[1] || i_dma_hit[1])) |-> qual_hit[1])
        else $error("channel c blocked by data bus");
    // [RULE5] after-execution fetch break waits
    fetch_after_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE5]
        (brk_late[2] && !(|brk_now) && !i_exec_done) |=> pend_reg[2])
        else $error("post-execution break lost");
    // [RULE5] retire releases break
    fetch_retire_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE5]
        ((|pend_reg) && i_exec_done) |=> o_break)
        else $error("pending break not raised at retire");
    // [RULE6] before-execution break immediate
    fetch_c_now_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [RULE6]
        (chan_fire[1] && !ctrl_reg[UBC_BIT_AFTER_C]) |=> o_break)
        else $error("channel c break delayed");
    // read data idles at zero
    rdata_idle_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        !i_read |=> (o_rdata == 32'h00000000))
        else $error("read data outside read cycle");
endmodule // ubc_break_ctrl

/* File: ubc_hit_source.sv */
// far-side model: cpu and dma bus cycles seen by the break channels
`timescale 1ns/1ps
module ubc_hit_source (
    input wire logic i_clock,
    output logic [3:0] o_cpu_hit,
    output logic [3:0] o_dma_hit,
    output logic [3:0] o_fetch,
    output logic o_data_hit_c,
    output logic o_data_hit_d,
    output logic o_exec_done
);
    initial begin
        o_cpu_hit = 4'h0;
        o_dma_hit = 4'h0;
        o_fetch = 4'h0;
        o_data_hit_c = 1'b0;
        o_data_hit_d = 1'b0;
        o_exec_done = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one matching bus cycle; qualifiers drop with it so none linger
    task automatic cycle(input bit dma, input int ch, input bit fet, input bit dat);
        @(posedge i_clock);
        if (dma) o_dma_hit[ch] <= 1'b1;
        else o_cpu_hit[ch] <= 1'b1;
        o_fetch[ch] <= fet;
        o_data_hit_c <= dat;
        o_data_hit_d <= dat;
        @(posedge i_clock);
        o_cpu_hit <= 4'h0;
        o_dma_hit <= 4'h0;
        o_fetch <= 4'h0;
        o_data_hit_c <= 1'b0;
        o_data_hit_d <= 1'b0;
    endtask
    // fetched instruction retires after gap cycles, prompt or slow
    task automatic retire(input int gap);
        repeat (gap) @(posedge i_clock);
        o_exec_done <= 1'b1;
        @(posedge i_clock);
        o_exec_done <= 1'b0;
    endtask
endmodule // ubc_hit_source

/* File: user_break_control_flags_bench.sv */
// testbench: break control flags, chaining, counts and interrupt
`timescale 1ns/1ps
module user_break_control_flags_bench;
    import ubc_pkg::*;
    localparam logic [31:0] FLAGS = 32'hC0C0C0C0;
    localparam logic [31:0] WR_BITS = 32'h0C1C2C2C;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_write = 1'b0;
    logic i_read = 1'b0;
    logic [3:0] cpu_hit;
    logic [3:0] dma_hit;
    logic [3:0] fetch;
    logic data_c;
    logic data_d;
    logic exec_done;
    logic [31:0] o_rdata;
    logic o_break;
    logic o_irq;
    logic o_after_b;
    logic o_after_c;
    logic o_data_en_c;
    int err_total = 0;
    int compares = 0;
    int brk_seen = 0;
    int brk_exp = 0;
    integer seed = 32'h7532a838;
    logic [31:0] m_ctrl = 32'h0;
    logic [31:0] rd_val;
    always #5 i_clock = ~i_clock;
    always @(posedge i_clock) if (o_break === 1'b1) brk_seen++;
    ubc_break_ctrl dut_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .i_cpu_hit(cpu_hit),
        .i_dma_hit(dma_hit), .i_fetch(fetch), .i_data_hit_c(data_c),
        .i_data_hit_d(data_d), .i_exec_done(exec_done), .o_rdata(o_rdata),
        .o_break(o_break), .o_irq(o_irq), .o_after_b(o_after_b),
        .o_after_c(o_after_c), .o_data_en_c(o_data_en_c));
    ubc_hit_source src_u (.i_clock(i_clock), .o_cpu_hit(cpu_hit), .o_dma_hit(dma_hit),
        .o_fetch(fetch), .o_data_hit_c(data_c), .o_data_hit_d(data_d),
        .o_exec_done(exec_done));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // break pulses counted against the model
    task automatic chk_brk();
        repeat (2) @(posedge i_clock);
        chk(32'(brk_seen), 32'(brk_exp));
    endtask
    // model keeps flags only where software writes 1
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
        if (a == UBC_OFS_CTRL) m_ctrl = (d & WR_BITS) | (m_ctrl & d & FLAGS);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1;
        d = o_rdata;
    endtask
    task automatic finish_test();
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
    initial begin : main
        int n;
        repeat (10) @(posedge i_clock);
        i_rstn <= 1'b1;
        rd(UBC_OFS_CTRL, rd_val);
        chk(rd_val, 32'h0);
        wr(UBC_OFS_CTRL, 32'hFFFFFFFF);
        rd(UBC_OFS_CTRL, rd_val);
        chk(rd_val, m_ctrl);
        wr(4'h2, 32'hFFFFFFFF);
        rd(4'h2, rd_val);
        chk(rd_val, 32'h0);
        wr(UBC_OFS_CTRL, 32'h0);
        // every channel, cpu then dma, flags accumulate
        for (int k = 0; k < 8; k++) begin
            src_u.cycle(k[0], k / 2, 1'b0, 1'b0);
            brk_exp++;
            m_ctrl |= 32'h1 << (7 + 8 * (k / 2) - k[0]);
            chk_brk();
            rd(UBC_OFS_CTRL, rd_val);
            chk(rd_val, m_ctrl);
        end
        wr(UBC_OFS_CTRL, 32'hC0C0C000);
        rd(UBC_OFS_CTRL, rd_val);
        chk(rd_val, m_ctrl);
        // status full but mask empty, then a random mask
        chk({31'h0, o_irq}, 32'h0);
        n = ($unsigned($random(seed)) & 32'hE) | 32'h8;
        wr(UBC_OFS_IRQ_STAT, 32'(n) << 4);
        repeat (2) @(posedge i_clock);
        chk({31'h0, o_irq}, 32'h1);
        rd(UBC_OFS_IRQ_STAT, rd_val);
        chk(rd_val, (32'(n) << 4) | 32'hF);
        repeat (2) @(posedge i_clock);
        chk({31'h0, o_irq}, 32'h0);
        src_u.cycle(1'b0, 0, 1'b0, 1'b0);
        brk_exp++;
        chk_brk();
        chk({31'h0, o_irq}, 32'h0);
        wr(UBC_OFS_IRQ_STAT, 32'hF0);
        repeat (2) @(posedge i_clock);
        chk({31'h0, o_irq}, 32'h1);
        // d alone, then a to d in order, for every chaining mode
        for (int m = 0; m < 4; m++) begin
            wr(UBC_OFS_CTRL, 32'(m) << UBC_BIT_CHAIN_LO);
            src_u.cycle(1'b0, 0, 1'b0, 1'b0);
            for (int ch = 3; ch >= 0; ch--) src_u.cycle(1'b0, ch, 1'b0, 1'b0);
            brk_exp += (m == 0) ? 5 : 4 - m;
            chk_brk();
        end
        m_ctrl = 32'h00180080;
        rd(UBC_OFS_CTRL, rd_val);
        chk(rd_val, m_ctrl);
        // count loaded at random, last two hits break
        for (int ch = 1; ch >= 0; ch--) begin
            n = 2 + ($unsigned($random(seed)) % 4);
            wr(ch ? UBC_OFS_CNT_C : UBC_OFS_CNT_D, 32'(n));
            wr(UBC_OFS_CTRL, ch ? 32'h2000 : 32'h20);
            for (int h = 0; h <= n; h++) begin
                src_u.cycle(1'b0, ch, 1'b0, 1'b0);
                if (h >= n - 1) brk_exp++;
                chk_brk();
            end
        end
        wr(UBC_OFS_CTRL, 32'h800);
        src_u.cycle(1'b0, 1, 1'b0, 1'b0);
        chk_brk();
        chk({31'h0, o_data_en_c}, 32'h1);
        src_u.cycle(1'b0, 1, 1'b0, 1'b1);
        brk_exp++;
        chk_brk();
        // break held until the fetched instruction retires
        for (int ch = 2; ch >= 1; ch--) begin
            wr(UBC_OFS_CTRL, ch == 2 ? 32'h40000 : 32'h400);
            src_u.cycle(1'b0, ch, 1'b1, 1'b0);
            chk_brk();
            chk({30'h0, o_after_b, o_after_c}, ch == 2 ? 32'h2 : 32'h1);
            src_u.retire($unsigned($random(seed)) % 4);
            brk_exp++;
            chk_brk();
        end
        wr(UBC_OFS_CTRL, 32'h0);
        src_u.cycle(1'b0, 2, 1'b1, 1'b0);
        brk_exp++;
        chk_brk();
        finish_test();
    end
endmodule // user_break_control_flags_bench
